// file: fbs_master_model.sv
// Master port model: whole frames, one byte per clock.
// Assumes send is called just after a rising edge.
`timescale 1ns/10ps
module fbs_master_model
(
   input wire logic clk_i,
   output fbs_pkg::fbs_byte_s rx_o
);
   import fbs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Idle line; data churns so a stale byte never looks valid
   initial
      rx_o = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: 8'hA5};
   always @(posedge clk_i)
      if (!rx_o.valid)
         rx_o.data <= ~rx_o.data;

   ////////////////////////////////////////////////////////////////////////////
   // Idle gap, then a contiguous frame
   task automatic send(input logic [7:0] q[$], input int gap);
      for (int i = 0; i < gap; i++)
      begin
         @(posedge clk_i);
         #1;
      end
      for (int i = 0; i < q.size(); i++)
      begin
         rx_o = '{valid: 1'b1, sof: i == 0, eof: i == q.size() - 1, data: q[i]};
         @(posedge clk_i);
         #1;
      end
      rx_o = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~rx_o.data};
   endtask
endmodule

// file: fbs_pkg.sv
// Package for the fieldbus slave frame processor: constants and carriers.
// Assumes one byte per clock on the stream and FCS handled by the port MAC.
// Contract
// - Frame: MACs, ethertype, header, data, FCS.
// - First slave swaps destination and source MAC.
// - Over UDP also swap IPs and ports.
// - Device address splits into station and offset.
// - Device sub-message served by one slave only.
// - Each slave adds one to position address.
// - Position address zero means this slave.
// - Configured mode matches position-independent station address.
// - Logical mode: whole 32-bit address, shared space.
// - Mapping units map logical ranges to memory.
// - Mapping hit inserts inputs and extracts outputs.
// - System time is 64-bit nanoseconds.
// - Truncated 32-bit time for stamps.
// - First clock-capable slave is reference clock.
// - Local clock corrected for offset and drift.
// - Working counter incremented per served sub-message.
package fbs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Frame layout, byte positions from the first destination byte
   localparam logic [15:0] ETYPE_FIELDBUS = 16'h88A4;
   localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
   localparam logic [7:0] IP_VER_IHL = 8'h45;    // Only 20-byte IP headers
   localparam logic [7:0] IP_PROTO_UDP = 8'h11;
   localparam int POS_SRC_MAC = 6;
   localparam int POS_ETYPE = 12;
   localparam int POS_IP_HDR = 14;
   localparam int POS_IP_PROTO = 23;
   localparam int POS_IP_SRC = 26;
   localparam int POS_IP_DST = 30;
   localparam int POS_UDP_SRC = 34;
   localparam int POS_UDP_DST = 36;
   localparam int POS_UDP_PAY = 42;
   localparam int FB_HDR_LEN = 2;                // Fieldbus header bytes
   localparam int SUB_HDR_LEN = 10;              // Sub-message header bytes
   localparam int DLY_LEN = 6;                   // Lookahead for the MAC swap

   ////////////////////////////////////////////////////////////////////////////
   // Sub-message command codes
   localparam logic [7:0] CMD_POS_RD = 8'h01;
   localparam logic [7:0] CMD_POS_WR = 8'h02;
   localparam logic [7:0] CMD_POS_RW = 8'h03;
   localparam logic [7:0] CMD_CFG_RD = 8'h04;
   localparam logic [7:0] CMD_CFG_WR = 8'h05;
   localparam logic [7:0] CMD_CFG_RW = 8'h06;
   localparam logic [7:0] CMD_LOG_RD = 8'h0A;
   localparam logic [7:0] CMD_LOG_WR = 8'h0B;
   localparam logic [7:0] CMD_LOG_RW = 8'h0C;

   ////////////////////////////////////////////////////////////////////////////
   // Memory, mapping units and clock
   localparam int MEM_AW = 6;
   localparam int MEM_DEPTH = 64;
   localparam int NUM_MAP = 2;
   localparam int CLK_HZ = 10000000;
   localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
   localparam logic [63:0] TIME_RESET = 64'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic valid;                               // Byte present
      logic sof;                                 // First byte of frame
      logic eof;                                 // Last byte of frame
      logic [7:0] data;
   } fbs_byte_s;

   typedef struct packed {
      logic enable;
      logic insert;                              // Memory to frame (inputs)
      logic extract;                             // Frame to memory (outputs)
      logic [31:0] log_start;
      logic [15:0] length;
      logic [MEM_AW-1:0] phys_start;
   } fbs_map_s;

   typedef enum logic [2:0] {
      ST_PASS,
      ST_ETH,
      ST_IPHDR,
      ST_FBHDR,
      ST_SUBHDR,
      ST_DATA,
      ST_WKC
   } fbs_state_e;

   typedef struct packed {
      fbs_byte_s [DLY_LEN-1:0] dly;              // dly[0] is one cycle old
      fbs_byte_s tx;
      fbs_state_e st;
      logic [10:0] pos;
      logic [10:0] cnt;
      logic [10:0] len;
      logic swap;
      logic udp;
      logic more;
      logic rd_ok;
      logic wr_ok;
      logic carry;
      logic [7:0] cmd;
      logic [7:0] app_rd;
      logic [15:0] adp;
      logic [15:0] ado;
      logic [5:0][7:0] held;
      logic [MEM_DEPTH-1:0][7:0] mem;
      logic [63:0] time_ns;
      logic [31:0] stamp;
   } fbs_reg_s;

endpackage

// file: fbs_slave.sv
// Fieldbus slave on-the-fly frame processor with local memory and clock.
// Assumes contiguous bytes, one per clock, FCS
// handled by the port MAC.
`timescale 1ns/10ps
module fbs_slave
(
   input wire logic SYS_CLK_I,
   input wire logic RESET_I,
   input fbs_pkg::fbs_byte_s RX_I,
   output fbs_pkg::fbs_byte_s TX_O,
   input wire logic SEG_SWAP_EN_I,
   input wire logic [47:0] SEG_MAC_I,
   input wire logic [15:0] STATION_ADDR_I,
   input fbs_pkg::fbs_map_s [fbs_pkg::NUM_MAP-1:0] MAP_CFG_I,
   input wire logic APP_WE_I,
   input wire logic [fbs_pkg::MEM_AW-1:0] APP_ADDR_I,
   input wire logic [7:0] APP_WDATA_I,
   output logic [7:0] APP_RDATA_O,
   input wire logic TIME_LOAD_I,
   input wire logic [63:0] TIME_VALUE_I,
   input wire logic signed [7:0] DRIFT_ADJ_I,
   input wire logic REF_CLOCK_I,
   output logic [63:0] SYS_TIME_O,
   output logic [31:0] SYS_TIME32_O,
   output logic [31:0] RX_STAMP_O
);
   import fbs_pkg::*;

   fbs_reg_s s_reg;                               // All state
   fbs_reg_s s_next;
   logic [NUM_MAP-1:0] map_hit;                   // Byte falls in a unit
   logic [NUM_MAP-1:0][MEM_AW-1:0] map_phys;      // Its local address

   ////////////////////////////////////////////////////////////////////////////
   // Mapping units, one per configured logical window
   for (genvar u = 0; u < NUM_MAP; u++)
   begin : g_map
      logic [31:0] log_addr;
      logic [31:0] off;
      // Whole 32-bit address is the logical position
      assign log_addr = {s_reg.ado, s_reg.adp} + 32'(s_reg.cnt);
      // Offset compare is wrap-safe against the window start
      assign off = log_addr - MAP_CFG_I[u].log_start;
      assign map_hit[u] = MAP_CFG_I[u].enable && (off < 32'(MAP_CFG_I[u].length));
      assign map_phys[u] = MAP_CFG_I[u].phys_start + off[MEM_AW-1:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for stream, parser, memory and clock
   always_comb
   begin
      fbs_byte_s in6;                             // Byte leaving the delay line
      fbs_state_e st;
      logic [10:0] cur;                           // Its position in the frame
      logic [7:0] b;
      logic [7:0] o;                              // Byte sent on
      logic [15:0] pa;
      logic [8:0] sum;
      logic [1:0] inc;
      logic sw;
      logic is_pos;
      logic is_cfg;
      logic is_log;
      logic do_rd;
      logic do_wr;
      logic dev_hit;
      in6 = s_reg.dly[DLY_LEN-1];
      st = s_reg.st;
      cur = s_reg.pos;
      b = in6.data;
      o = in6.data;
      pa = '0;
      sum = '0;
      inc = '0;
      sw = s_reg.swap;
      s_next = s_reg;

      // Fixed lookahead so the source MAC can be sent first
      s_next.dly[0] = RX_I;
      for (int k = 1; k < DLY_LEN; k++)
      begin
         s_next.dly[k] = s_reg.dly[k-1];
      end

      // Command class decode
      is_pos = (s_reg.cmd == CMD_POS_RD) || (s_reg.cmd == CMD_POS_WR)
         || (s_reg.cmd == CMD_POS_RW);
      is_cfg = (s_reg.cmd == CMD_CFG_RD) || (s_reg.cmd == CMD_CFG_WR)
         || (s_reg.cmd == CMD_CFG_RW);
      is_log = (s_reg.cmd == CMD_LOG_RD) || (s_reg.cmd == CMD_LOG_WR)
         || (s_reg.cmd == CMD_LOG_RW);
      do_rd = (s_reg.cmd == CMD_POS_RD) || (s_reg.cmd == CMD_POS_RW)
         || (s_reg.cmd == CMD_CFG_RD) || (s_reg.cmd == CMD_CFG_RW)
         || (s_reg.cmd == CMD_LOG_RD) || (s_reg.cmd == CMD_LOG_RW);
      do_wr = (s_reg.cmd == CMD_POS_WR) || (s_reg.cmd == CMD_POS_RW)
         || (s_reg.cmd == CMD_CFG_WR) || (s_reg.cmd == CMD_CFG_RW)
         || (s_reg.cmd == CMD_LOG_WR) || (s_reg.cmd == CMD_LOG_RW);
      // Position zero or own station: one slave only
      dev_hit = (is_pos && (s_reg.adp == 16'h0000))
         || (is_cfg && (s_reg.adp == STATION_ADDR_I));

      // Application side access; a frame write below wins a clash
      s_next.app_rd = s_reg.mem[APP_ADDR_I];
      if (APP_WE_I)
      begin
         s_next.mem[APP_ADDR_I] = APP_WDATA_I;
      end

      if (in6.valid)
      begin
         // New frame: reset the parser, decide on swapping
         if (in6.sof)
         begin
            cur = '0;
            st = ST_ETH;
            s_next.udp = 1'b0;
            // Only frames aimed at the segment MAC are answered swapped
            sw = SEG_SWAP_EN_I && ({s_reg.dly[5].data, s_reg.dly[4].data,
               s_reg.dly[3].data, s_reg.dly[2].data, s_reg.dly[1].data,
               s_reg.dly[0].data} == SEG_MAC_I);
         end

         // Address swap on the Ethernet, IP and UDP levels
         if (sw)
         begin
            if (int'(cur) < POS_SRC_MAC)
            begin
               o = RX_I.data;
            end
            else if (int'(cur) < POS_ETYPE)
            begin
               // Segment MAC becomes the source
               o = SEG_MAC_I[8 * (POS_ETYPE - 1 - int'(cur)) +: 8];
            end
            else if (s_reg.udp && int'(cur) >= POS_IP_SRC && int'(cur) < POS_IP_DST)
            begin
               o = s_reg.dly[1].data;
               s_next.held[3'(int'(cur) - POS_IP_SRC)] = b;
            end
            else if (s_reg.udp && int'(cur) >= POS_IP_DST && int'(cur) < POS_UDP_SRC)
            begin
               o = s_reg.held[3'(int'(cur) - POS_IP_DST)];
            end
            else if (s_reg.udp && int'(cur) >= POS_UDP_SRC && int'(cur) < POS_UDP_DST)
            begin
               o = s_reg.dly[3].data;
               s_next.held[3'(int'(cur) - POS_UDP_SRC + 4)] = b;
            end
            else if (s_reg.udp && int'(cur) >= POS_UDP_DST && int'(cur) < POS_UDP_PAY - 4)
            begin
               o = s_reg.held[3'(int'(cur) - POS_UDP_DST + 4)];
            end
         end

         // Protocol walk
         case (st)
            ST_ETH:
            begin
               if (int'(cur) == POS_ETYPE)
               begin
                  s_next.cmd = b;
               end
               else if (int'(cur) == POS_ETYPE + 1)
               begin
                  s_next.cnt = '0;
                  // Anything else is left unparsed; only the MAC swap applies
                  if ({s_reg.cmd, b} == ETYPE_FIELDBUS)
                  begin
                     st = ST_FBHDR;
                  end
                  else if ({s_reg.cmd, b} == ETYPE_IPV4)
                  begin
                     st = ST_IPHDR;
                  end
                  else
                  begin
                     st = ST_PASS;
                  end
               end
            end
            ST_IPHDR:
            begin
               // Options shift the payload, so such frames pass with only the MAC swap
               if (int'(cur) == POS_IP_HDR && b != IP_VER_IHL)
               begin
                  st = ST_PASS;
               end
               else if (int'(cur) == POS_IP_PROTO)
               begin
                  s_next.udp = (b == IP_PROTO_UDP);
               end
               else if (int'(cur) == POS_UDP_PAY - 1)
               begin
                  st = s_reg.udp ? ST_FBHDR : ST_PASS;
                  s_next.cnt = '0;
               end
            end
            ST_FBHDR:
            begin
               s_next.cnt = s_reg.cnt + 11'h001;
               if (int'(s_reg.cnt) == FB_HDR_LEN - 1)
               begin
                  st = ST_SUBHDR;
                  s_next.cnt = '0;
               end
            end
            ST_SUBHDR:
            begin
               s_next.cnt = s_reg.cnt + 11'h001;
               case (s_reg.cnt)
                  11'h000: s_next.cmd = b;
                  11'h002:
                  begin
                     // Low byte of station field, bumped on the way out for position commands
                     s_next.adp[7:0] = b;
                     if (is_pos)
                     begin
                        o = b + 8'h01;
                     end
                  end
                  11'h003:
                  begin
                     s_next.adp[15:8] = b;
                     if (is_pos && s_reg.adp[7:0] == 8'hFF)
                     begin
                        o = b + 8'h01;
                     end
                  end
                  11'h004: s_next.ado[7:0] = b;
                  11'h005: s_next.ado[15:8] = b;
                  11'h006: s_next.len[7:0] = b;
                  11'h007:
                  begin
                     s_next.len[10:8] = b[2:0];
                     s_next.more = b[7];
                  end
                  default:
                  begin
                     // Last header byte: start the data phase
                     if (int'(s_reg.cnt) == SUB_HDR_LEN - 1)
                     begin
                        s_next.rd_ok = 1'b0;
                        s_next.wr_ok = 1'b0;
                        s_next.cnt = '0;
                        st = (s_reg.len == 11'h000) ? ST_WKC : ST_DATA;
                     end
                  end
               endcase
            end
            ST_DATA:
            begin
               s_next.cnt = s_reg.cnt + 11'h001;
               pa = s_reg.ado + {5'h00, s_reg.cnt};
               // Device access, only inside the local memory
               if (dev_hit && pa < 16'(MEM_DEPTH))
               begin
                  if (do_rd)
                  begin
                     o = s_reg.mem[pa[MEM_AW-1:0]];
                     s_next.rd_ok = 1'b1;
                  end
                  if (do_wr)
                  begin
                     s_next.mem[pa[MEM_AW-1:0]] = b;
                     s_next.wr_ok = 1'b1;
                  end
               end
               // Logical access; later units override earlier ones
               for (int u = 0; u < NUM_MAP; u++)
               begin
                  if (is_log && map_hit[u])
                  begin
                     if (do_rd && MAP_CFG_I[u].insert)
                     begin
                        o = s_reg.mem[map_phys[u]];
                        s_next.rd_ok = 1'b1;
                     end
                     if (do_wr && MAP_CFG_I[u].extract)
                     begin
                        s_next.mem[map_phys[u]] = b;
                        s_next.wr_ok = 1'b1;
                     end
                  end
               end
               if (s_reg.cnt == s_reg.len - 11'h001)
               begin
                  st = ST_WKC;
                  s_next.cnt = '0;
               end
            end
            ST_WKC:
            begin
               s_next.cnt = s_reg.cnt + 11'h001;
               if (s_reg.cnt == 11'h000)
               begin
                  // Combined commands weigh read 1 and write 2
                  if (do_rd && do_wr)
                  begin
                     inc = {s_reg.wr_ok, s_reg.rd_ok};
                  end
                  else
                  begin
                     inc = {1'b0, s_reg.rd_ok | s_reg.wr_ok};
                  end
                  sum = {1'b0, b} + {7'h00, inc};
                  o = sum[7:0];
                  s_next.carry = sum[8];
               end
               else
               begin
                  o = b + {7'h00, s_reg.carry};
                  st = s_reg.more ? ST_SUBHDR : ST_PASS;
                  s_next.cnt = '0;
               end
            end
            default: st = ST_PASS;
         endcase

         if (in6.eof)
         begin
            st = ST_PASS;
         end
         s_next.pos = cur + 11'h001;
      end

      s_next.st = st;
      s_next.swap = sw;
      s_next.tx = in6;
      s_next.tx.data = o;

      // Time counts whole nanoseconds; the reference runs uncorrected
      if (TIME_LOAD_I)
      begin
         s_next.time_ns = TIME_VALUE_I;
      end
      else if (REF_CLOCK_I)
      begin
         s_next.time_ns = s_reg.time_ns + 64'(CLK_PERIOD_NS);
      end
      else
      begin
         s_next.time_ns = s_reg.time_ns + 64'(CLK_PERIOD_NS)
            + {{56{DRIFT_ADJ_I[7]}}, DRIFT_ADJ_I};
      end
      // Arrival stamp in the short time form
      if (RX_I.valid && RX_I.sof)
      begin
         s_next.stamp = s_reg.time_ns[31:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
      begin
         s_reg <= '0;
         s_reg.time_ns <= TIME_RESET;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops
   assign TX_O = s_reg.tx;
   assign APP_RDATA_O = s_reg.app_rd;
   assign SYS_TIME_O = s_reg.time_ns;
   assign SYS_TIME32_O = s_reg.time_ns[31:0];
   assign RX_STAMP_O = s_reg.stamp;

endmodule

// file: fbs_slave_properties.sv
// Port checks on the fieldbus slave, bound into it.
// Assumes contiguous frames; app writes only on an idle line.
`timescale 1ns/10ps
module fbs_slave_properties
(
   input wire logic SYS_CLK_I,
   input wire logic RESET_I,
   input fbs_pkg::fbs_byte_s RX_I,
   input fbs_pkg::fbs_byte_s TX_O,
   input wire logic SEG_SWAP_EN_I,
   input wire logic APP_WE_I,
   input wire logic [fbs_pkg::MEM_AW-1:0] APP_ADDR_I,
   input wire logic [7:0] APP_WDATA_I,
   input wire logic [7:0] APP_RDATA_O,
   input wire logic TIME_LOAD_I,
   input wire logic [63:0] TIME_VALUE_I,
   input wire logic signed [7:0] DRIFT_ADJ_I,
   input wire logic REF_CLOCK_I,
   input wire logic [63:0] SYS_TIME_O,
   input wire logic [31:0] SYS_TIME32_O,
   input wire logic [31:0] RX_STAMP_O
);
   import fbs_pkg::*;
   default clocking @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RESET_I);

   ////////////////////////////////////////////////////////////////////////////
   logic [3:0] warm_reg; // Edges since reset, saturating
   logic [3:0] idle_reg; // Edges without input bytes, saturating
   logic [63:0] step; // Time step per edge

   // Keep $past depths clear of reset
   always_ff @(posedge SYS_CLK_I)
   begin
      warm_reg <= RESET_I ? 4'h0 : warm_reg + {3'h0, warm_reg != 4'hF};
      idle_reg <= (RESET_I || RX_I.valid) ? 4'h0 : idle_reg + {3'h0, idle_reg != 4'hF};
   end
   // Reference clock ignores the drift trim
   assign step = 64'h64 + (REF_CLOCK_I ? 64'h0 : {{56{DRIFT_ADJ_I[7]}}, DRIFT_ADJ_I});

   ////////////////////////////////////////////////////////////////////////////
   sequence s_frame_start;
      RX_I.valid && RX_I.sof;
   endsequence
   sequence s_foreign_type;
      ##12 (RX_I.data != 8'h88 && RX_I.data != 8'h08);
   endsequence

   a_tx_latency: assert property (warm_reg > 4'h8 |-> TX_O.valid == $past(RX_I.valid, 7)
      && TX_O.sof == $past(RX_I.sof, 7) && TX_O.eof == $past(RX_I.eof, 7))
      else $error("output marks out of step");
   a_marks_valid: assert property ((TX_O.sof || TX_O.eof) |-> TX_O.valid)
      else $error("frame mark without valid byte");
   a_noswap_pass: assert property (s_frame_start ##0 !SEG_SWAP_EN_I
      |-> ##7 (TX_O.data == $past(RX_I.data, 7)) [*8])
      else $error("bytes changed without swap");
   a_foreign_pass: assert property (s_frame_start ##0 s_foreign_type
      |-> ##7 (TX_O.data == $past(RX_I.data, 7)) [*8])
      else $error("foreign frame modified");
   a_time_step: assert property (!TIME_LOAD_I |=> SYS_TIME_O == $past(SYS_TIME_O) + $past(step))
      else $error("system time step wrong");
   a_time_load: assert property (TIME_LOAD_I |=> SYS_TIME_O == $past(TIME_VALUE_I))
      else $error("system time not loaded");
   a_time_trunc: assert property (SYS_TIME32_O == SYS_TIME_O[31:0])
      else $error("short time differs");
   a_rx_stamp: assert property (s_frame_start |=> RX_STAMP_O == $past(SYS_TIME32_O))
      else $error("receive stamp wrong");
   a_app_readback: assert property (APP_WE_I && idle_reg > 4'h8 ##1 APP_ADDR_I == $past(APP_ADDR_I)
      |=> APP_RDATA_O == $past(APP_WDATA_I, 2))
      else $error("app write lost");
endmodule

bind fbs_slave fbs_slave_properties u_props (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
   .RX_I(RX_I), .TX_O(TX_O), .SEG_SWAP_EN_I(SEG_SWAP_EN_I), .APP_WE_I(APP_WE_I),
   .APP_ADDR_I(APP_ADDR_I), .APP_WDATA_I(APP_WDATA_I), .APP_RDATA_O(APP_RDATA_O),
   .TIME_LOAD_I(TIME_LOAD_I), .TIME_VALUE_I(TIME_VALUE_I), .DRIFT_ADJ_I(DRIFT_ADJ_I),
   .REF_CLOCK_I(REF_CLOCK_I), .SYS_TIME_O(SYS_TIME_O), .SYS_TIME32_O(SYS_TIME32_O),
   .RX_STAMP_O(RX_STAMP_O));

// file: fbs_slave_test.sv
// Bench: random frames of every command, swaps, foreign types, time.
// Assumes the master model feeds the stream; checker is bound.
`timescale 1ns/10ps
module fbs_slave_test;
   import fbs_pkg::*;

   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   fbs_byte_s rx;
   fbs_byte_s tx;
   logic swap_en = 1'b0;
   logic [47:0] seg_mac = 48'h0;
   logic [15:0] station = 16'h0;
   fbs_map_s [NUM_MAP-1:0] map_cfg = '0;
   logic app_we = 1'b0;
   logic [MEM_AW-1:0] app_addr = 6'h0;
   logic [7:0] app_wdata = 8'h0;
   logic [7:0] app_rdata;
   logic time_load = 1'b0;
   logic [63:0] time_value = 64'h0;
   logic signed [7:0] drift = 8'sh0;
   logic ref_clk = 1'b1;
   logic [63:0] sys_time;
   logic [31:0] sys_time32;
   logic [31:0] rx_stamp;
   logic [31:0] lfsr = 32'h4eb2ba04; // Fixed seed
   int num_errors = 0;
   int checked = 0;
   logic [7:0] fr[$]; // Frame sent
   logic [7:0] ex[$]; // Frame expected back
   logic [7:0] got[$]; // Frame seen at the output
   logic [7:0] cmds[0:8] = '{CMD_POS_RD, CMD_POS_WR, CMD_POS_RW, CMD_CFG_RD, CMD_CFG_WR,
      CMD_CFG_RW, CMD_LOG_RD, CMD_LOG_WR, CMD_LOG_RW};

   always #50 sys_clk = ~sys_clk;

   fbs_slave dut (.SYS_CLK_I(sys_clk), .RESET_I(reset), .RX_I(rx), .TX_O(tx),
      .SEG_SWAP_EN_I(swap_en), .SEG_MAC_I(seg_mac), .STATION_ADDR_I(station),
      .MAP_CFG_I(map_cfg), .APP_WE_I(app_we), .APP_ADDR_I(app_addr), .APP_WDATA_I(app_wdata),
      .APP_RDATA_O(app_rdata), .TIME_LOAD_I(time_load), .TIME_VALUE_I(time_value),
      .DRIFT_ADJ_I(drift), .REF_CLOCK_I(ref_clk), .SYS_TIME_O(sys_time),
      .SYS_TIME32_O(sys_time32), .RX_STAMP_O(rx_stamp));
   fbs_master_model master (.clk_i(sys_clk), .rx_o(rx));

   // Collect output bytes
   always @(posedge sys_clk)
      if (tx.valid === 1'b1)
         got.push_back(tx.data);

   ////////////////////////////////////////////////////////////////////////////
   task automatic roll();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
   endtask
   // Counter gain: rw scores three when both land
   function automatic logic [15:0] exp_wkc(input logic [15:0] w, input logic [7:0] cmd,
      input logic srv);
      return w + (!srv ? 16'h0 : (cmd % 8'h03 == 8'h00) ? 16'h3 : 16'h1);
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      checked++;
      if (seen !== want)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // One frame, one sub-message; memory preset by the app port
   task automatic run_frame(input logic [7:0] cmd, input logic hit, input logic udp,
      input logic alien);
      int s;
      logic [31:0] addr;
      logic [5:0] pa;
      logic [7:0] m;
      logic [7:0] d;
      logic [7:0] kind;
      logic [15:0] w;
      logic [15:0] t;
      logic srv;
      s = (udp ? POS_UDP_PAY : POS_IP_HDR) + FB_HDR_LEN;
      roll();
      swap_en = !alien && lfsr[3];
      {w, m, d} = {lfsr[31:8], lfsr[7:0] ^ lfsr[23:16]};
      roll();
      pa = lfsr[5:0];
      addr = {10'h0, pa, cmd <= CMD_POS_RW ? (hit ? 16'h0 : 16'hFFFF - {14'h0, lfsr[7:6]})
         : (hit ? station : station ^ 16'h0100)};
      if (cmd >= CMD_LOG_RD)
      begin
         addr = map_cfg[0].log_start + {28'h0, lfsr[3:0]} + (hit ? 32'h0 : 32'h10);
         pa = map_cfg[0].phys_start + {2'h0, lfsr[3:0]};
      end
      app_we = 1'b1;
      app_addr = pa;
      app_wdata = m;
      @(posedge sys_clk);
      #1;
      app_we = 1'b0;
      fr = {};
      for (int i = 0; i < 60; i++)
      begin
         roll();
         fr.push_back(lfsr[7:0]);
      end
      for (int i = 0; i < 6; i++)
         fr[i] = swap_en ? seg_mac[47 - 8 * i -: 8] : 8'hFF;
      fr[12] = alien ? 8'h86 : (udp ? ETYPE_IPV4[15:8] : ETYPE_FIELDBUS[15:8]);
      fr[13] = alien ? 8'hDD : (udp ? ETYPE_IPV4[7:0] : ETYPE_FIELDBUS[7:0]);
      if (udp)
         {fr[POS_IP_HDR], fr[POS_IP_PROTO]} = {IP_VER_IHL, IP_PROTO_UDP};
      {fr[s], fr[s + 2], fr[s + 3], fr[s + 4], fr[s + 5]} = {cmd, addr[7:0], addr[15:8],
         addr[23:16], addr[31:24]};
      {fr[s + 6], fr[s + 7], fr[s + 10], fr[s + 11], fr[s + 12]} = {16'h0100, d, w[7:0], w[15:8]};
      kind = cmd % 8'h03;
      srv = hit && !alien;
      ex = fr;
      t = addr[15:0] + 16'h1;
      if (!alien && cmd <= CMD_POS_RW)
         {ex[s + 3], ex[s + 2]} = t;
      if (srv && kind != 8'h02)
         ex[s + 10] = m;
      t = exp_wkc(w, cmd, srv);
      if (!alien)
         {ex[s + 12], ex[s + 11]} = t;
      for (int i = 0; i < 6 && swap_en; i++)
         {ex[i], ex[i + 6]} = {fr[i + 6], seg_mac[47 - 8 * i -: 8]};
      for (int i = POS_IP_SRC; i < POS_UDP_PAY - 4 && swap_en && udp; i++)
         ex[i] = fr[i < POS_UDP_SRC ? (i < POS_IP_DST ? i + 4 : i - 4)
            : (i < POS_UDP_DST ? i + 2 : i - 2)];
      got = {};
      master.send(fr, int'(lfsr[1:0]));
      for (int i = 0; i < 20 && got.size() < fr.size(); i++)
         @(posedge sys_clk);
      #1;
      if (got.size() != fr.size())
      begin
         num_errors++;
         $display("[ERR] %0t frame output incomplete", $time);
         tally_and_finish();
      end
      for (int i = 0; i < 60; i++)
         check(got[i], ex[i]);
      repeat (2) @(posedge sys_clk);
      #1;
      check(app_rdata, (srv && kind != 8'h01) ? d : m);
      $display("Frame cmd %h hit %0b udp %0b foreign %0b done", cmd, hit, udp, alien);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge sys_clk);
      #1;
      check(tx, 64'h0);
      check(app_rdata, 8'h0);
      check(sys_time, 64'h0);
      reset = 1'b0;
      roll();
      {seg_mac[47:32], station} = lfsr;
      roll();
      seg_mac[31:0] = lfsr;
      roll();
      map_cfg[0] = '{enable: 1'b1, insert: 1'b1, extract: 1'b1, log_start: lfsr,
         length: 16'h10, phys_start: lfsr[13:8]};
      for (int it = 0; it < 27; it++)
      begin
         roll();
         run_frame(cmds[it % 9], it < 9 || lfsr[0], it[0], it % 7 == 6);
      end
      $display("Frame tests done");
      // Time: load, untrimmed, then trimmed steps
      roll();
      time_value[31:0] = lfsr;
      roll();
      time_value[63:32] = lfsr;
      drift = lfsr[7:0] | 8'h01;
      time_load = 1'b1;
      @(posedge sys_clk);
      #1;
      time_load = 1'b0;
      repeat (10) @(posedge sys_clk);
      #1;
      check(sys_time, time_value + 64'h3E8);
      check(sys_time32, time_value[31:0] + 32'h3E8);
      ref_clk = 1'b0;
      repeat (10) @(posedge sys_clk);
      #1;
      check(sys_time, time_value + 64'h7D0 + {{56{drift[7]}}, drift} * 64'hA);
      $display("Time test done");
      tally_and_finish();
   end
endmodule
